// ### dco_pull_pkg.sv
package dco_pull_pkg;
	localparam int CLK_MHZ = 100;
	localparam int PULL_DELAY_US = 103;
	localparam int PULL_DELAY_CYC = PULL_DELAY_US * CLK_MHZ;
	localparam int PULL_SETTLE_US = 20;
	localparam int PULL_SETTLE_CYC = PULL_SETTLE_US * CLK_MHZ;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_WORD_LOW = 8'h00;
	localparam logic [7:0] ADDR_WORD_HIGH = 8'h01;
	localparam logic [7:0] ADDR_SPAN = 8'h02;
	localparam logic [7:0] ADDR_SYNTH_INT = 8'h03;
	localparam logic [7:0] ADDR_SYNTH_FRAC = 8'h04;
	localparam logic [7:0] ADDR_OUT_DIV = 8'h05;
	localparam logic [7:0] ADDR_DRV_STAGE = 8'h06;
	localparam int HIGH_MSB = 9;
	localparam int OE_BIT = 10;
	localparam int SPAN_MSB = 3;
	localparam int INT_MSB = 15;
	localparam int INT_LSB = 11;
	localparam int FRAC_HI_MSB = 10;
	localparam int OUTPUT_DIVIDER_AND_DRIVE_HIGH_MSB = 15;
	localparam int OUTPUT_DIVIDER_AND_DRIVE_HIGH_LSB = 3;
	localparam int DRV_MSB = 2;
	localparam int MDRV_BIT = 3;
	localparam int WORD_W = 26;
	localparam int SPAN_W = 12;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [11:0] SPAN_PPM_TABLE [16] = '{
		12'h019, 12'h032, 12'h050, 12'h064, 12'h07D, 12'h096, 12'h0C8, 12'h190,
		12'h258, 12'h320, 12'h4B0, 12'h640, 12'hC80, 12'h000, 12'h000, 12'h000};
	typedef enum logic [1:0] {
		PULL_IDLE   = 2'b00,
		PULL_DELAY  = 2'b01,
		PULL_SETTLE = 2'b10
	} pull_state_t;
endpackage

// ### dco_pull_and_oe_registers.sv
`timescale 1ns/1ps
module dco_pull_and_oe_registers
	import dco_pull_pkg::*;
#(
	parameter int PULL_DELAY_CYCLES = PULL_DELAY_CYC
)(
	input  wire logic                clock_in,
	input  wire logic                reset_n_in,
	input  wire logic                wr_en_in,
	input  wire logic [ADDR_W-1:0]   wr_addr_in,
	input  wire logic [DATA_W-1:0]   wr_data_in,
	input  wire logic                rd_en_in,
	input  wire logic [ADDR_W-1:0]   rd_addr_in,
	input  wire logic                sw_oe_select_in,
	input  wire logic                oe_pin_in,
	output logic [DATA_W-1:0]        rd_data_out,
	output logic                     rd_valid_out,
	output logic [WORD_W-1:0]        applied_word_out,
	output logic [SPAN_W-1:0]        span_ppm_out,
	output logic                     pull_start_out,
	output logic                     pull_busy_out,
	output logic                     pull_settled_out,
	output logic                     output_enable_out,
	output logic [4:0]               synth_int_out,
	output logic [26:0]              synth_frac_out,
	output logic [12:0]              out_div_out,
	output logic                     drv_stage_div_out,
	output logic [5:0]               drive_ctrl_out
);
	function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] off);
		hit = en && (a == off);
	endfunction

	logic [15:0]  word_low_r;
	logic [9:0]   word_high_r;
	logic         oe_bit_r;
	logic [3:0]   span_sel_r;
	logic [4:0]   synth_int_r;
	logic [10:0]  frac_hi_r;
	logic [15:0]  frac_lo_r;
	logic [12:0]  out_div_r;
	logic [2:0]   drv_hi_r;
	logic         mdrv_r;
	logic [2:0]   drv_lo_r;
	logic [2:0]   sel_sync_r;
	logic [2:0]   pin_sync_r;
	logic         sw_mode_r;
	logic         oe_pin_r;
	pull_state_t  state_r;
	logic [15:0]  cnt_r;
	logic [15:0]  rd_mux;
	logic         wr_high;
	logic [15:0]  since_high_r;
	logic [15:0]  since_start_r;
	assign wr_high = hit(wr_en_in, wr_addr_in, ADDR_WORD_HIGH);

	// pin inputs pass three stages
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sel_sync_r <= 3'h0;
			pin_sync_r <= 3'h0;
			sw_mode_r  <= 1'b0;
			oe_pin_r   <= 1'b0;
		end
		else
		begin
			sel_sync_r <= {sel_sync_r[1:0], sw_oe_select_in};
			pin_sync_r <= {pin_sync_r[1:0], oe_pin_in};
			if (sel_sync_r[1] == sel_sync_r[2])
				sw_mode_r <= sel_sync_r[2];
			if (pin_sync_r[1] == pin_sync_r[2])
				oe_pin_r <= pin_sync_r[2];
		end
	end

	// control word registers
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			word_low_r  <= RESET_WORD;
			word_high_r <= 10'h000;
		end
		else
		begin
			if (hit(wr_en_in, wr_addr_in, ADDR_WORD_LOW))
				word_low_r <= wr_data_in;
			if (wr_high)
				word_high_r <= wr_data_in[HIGH_MSB:0];
		end
	end

	// software enable bit
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			oe_bit_r <= 1'b0;
		else if (wr_high && sw_mode_r)
			oe_bit_r <= wr_data_in[OE_BIT];
	end

	// span, synthesizer, output divider and drive registers
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			span_sel_r  <= 4'h0;
			synth_int_r <= 5'h00;
			frac_hi_r   <= 11'h000;
			frac_lo_r   <= 16'h0000;
			out_div_r   <= 13'h0000;
			drv_hi_r    <= 3'h0;
			mdrv_r      <= 1'b0;
			drv_lo_r    <= 3'h0;
		end
		else
		begin
			if (hit(wr_en_in, wr_addr_in, ADDR_SPAN))
				span_sel_r <= wr_data_in[SPAN_MSB:0];
			if (hit(wr_en_in, wr_addr_in, ADDR_SYNTH_INT))
			begin
				synth_int_r <= wr_data_in[INT_MSB:INT_LSB];
				frac_hi_r   <= wr_data_in[FRAC_HI_MSB:0];
			end
			if (hit(wr_en_in, wr_addr_in, ADDR_SYNTH_FRAC))
				frac_lo_r <= wr_data_in;
			if (hit(wr_en_in, wr_addr_in, ADDR_OUT_DIV))
			begin
				out_div_r <= wr_data_in[OUTPUT_DIVIDER_AND_DRIVE_HIGH_MSB:OUTPUT_DIVIDER_AND_DRIVE_HIGH_LSB];
				drv_hi_r  <= wr_data_in[DRV_MSB:0];
			end
			if (hit(wr_en_in, wr_addr_in, ADDR_DRV_STAGE))
			begin
				mdrv_r   <= wr_data_in[MDRV_BIT];
				drv_lo_r <= wr_data_in[DRV_MSB:0];
			end
		end
	end

	// read mux
	always_comb
	begin
		rd_mux = 16'h0000;
		case (rd_addr_in)
			ADDR_WORD_LOW:   rd_mux = word_low_r;
			ADDR_WORD_HIGH:  rd_mux = {5'h00, oe_bit_r, word_high_r};
			ADDR_SPAN:       rd_mux = {12'h000, span_sel_r};
			ADDR_SYNTH_INT:  rd_mux = {synth_int_r, frac_hi_r};
			ADDR_SYNTH_FRAC: rd_mux = frac_lo_r;
			ADDR_OUT_DIV:    rd_mux = {out_div_r, drv_hi_r};
			ADDR_DRV_STAGE:  rd_mux = {12'h000, mdrv_r, drv_lo_r};
			default:         rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			rd_valid_out <= rd_en_in;
			if (rd_en_in)
				rd_data_out <= rd_mux;
		end
	end

	// pull sequencer
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r          <= PULL_IDLE;
			cnt_r            <= 16'h0000;
			pull_start_out   <= 1'b0;
			pull_settled_out <= 1'b0;
			pull_busy_out    <= 1'b0;
			applied_word_out <= 26'h0000000;
		end
		else
		begin
			pull_start_out <= 1'b0;
			if (wr_high)
			begin
				state_r          <= PULL_DELAY;
				cnt_r            <= 16'(PULL_DELAY_CYCLES - 1);
				pull_settled_out <= 1'b0;
				pull_busy_out    <= 1'b1;
			end
			else
			begin
				case (state_r)
					PULL_IDLE:
						cnt_r <= 16'h0000;
					PULL_DELAY:
						if (cnt_r == 16'h0000)
						begin
							applied_word_out <= {word_high_r, word_low_r};
							pull_start_out   <= 1'b1;
							state_r          <= PULL_SETTLE;
							cnt_r            <= 16'(PULL_SETTLE_CYC - 1);
						end
						else
							cnt_r <= cnt_r - 16'h0001;
					PULL_SETTLE:
						if (cnt_r == 16'h0000)
						begin
							pull_settled_out <= 1'b1;
							pull_busy_out    <= 1'b0;
							state_r          <= PULL_IDLE;
						end
						else
							cnt_r <= cnt_r - 16'h0001;
					default:
						state_r <= PULL_IDLE;
				endcase
			end
		end
	end

	// output enable and config outputs
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			output_enable_out <= 1'b0;
			span_ppm_out      <= 12'h000;
			synth_int_out     <= 5'h00;
			synth_frac_out    <= 27'h0000000;
			out_div_out       <= 13'h0000;
			drv_stage_div_out <= 1'b0;
			drive_ctrl_out    <= 6'h00;
		end
		else
		begin
			output_enable_out <= sw_mode_r ? oe_bit_r : oe_pin_r;
			span_ppm_out      <= SPAN_PPM_TABLE[span_sel_r];
			synth_int_out     <= synth_int_r;
			synth_frac_out    <= {frac_hi_r, frac_lo_r};
			out_div_out       <= out_div_r;
			drv_stage_div_out <= mdrv_r;
			drive_ctrl_out    <= {drv_hi_r, drv_lo_r};
		end
	end
	// assertion helpers
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			since_high_r  <= 16'hFFFF;
			since_start_r <= 16'hFFFF;
		end
		else
		begin
			if (wr_high)
				since_high_r <= 16'h0000;
			else if (since_high_r != 16'hFFFF)
				since_high_r <= since_high_r + 16'h0001;
			if (state_r == PULL_DELAY && cnt_r == 16'h0000 && !wr_high)
				since_start_r <= 16'h0000;
			else if (since_start_r != 16'hFFFF)
				since_start_r <= since_start_r + 16'h0001;
		end
	end
	property p_low_store;
		@(posedge clock_in) disable iff (!reset_n_in)
		hit(wr_en_in, wr_addr_in, ADDR_WORD_LOW) |=> word_low_r == $past(wr_data_in);
	endproperty
	a_low_store: assert property (p_low_store) else $error("lower word not stored");
	property p_high_store;
		@(posedge clock_in) disable iff (!reset_n_in)
		wr_high |=> word_high_r == $past(wr_data_in[HIGH_MSB:0]);
	endproperty
	a_high_store: assert property (p_high_store) else $error("upper word not stored");
	property p_span_read;
		@(posedge clock_in) disable iff (!reset_n_in)
		rd_en_in && rd_addr_in == ADDR_SPAN |=> rd_valid_out && rd_data_out[15:4] == 12'h000
			&& rd_data_out[3:0] == $past(span_sel_r);
	endproperty
	a_span_read: assert property (p_span_read) else $error("span readback wrong");
	property p_synth_store;
		@(posedge clock_in) disable iff (!reset_n_in)
		hit(wr_en_in, wr_addr_in, ADDR_SYNTH_INT) |=> ##1
			synth_int_out == $past(wr_data_in[INT_MSB:INT_LSB], 2)
			&& synth_frac_out[26:16] == $past(wr_data_in[FRAC_HI_MSB:0], 2);
	endproperty
	a_synth_store: assert property (p_synth_store) else $error("synth divider wrong");
	property p_frac_lo;
		@(posedge clock_in) disable iff (!reset_n_in)
		hit(wr_en_in, wr_addr_in, ADDR_SYNTH_FRAC) |=> ##1
			synth_frac_out[15:0] == $past(wr_data_in, 2);
	endproperty
	a_frac_lo: assert property (p_frac_lo) else $error("fraction low wrong");
	property p_start_delay;
		@(posedge clock_in) disable iff (!reset_n_in)
		pull_start_out |-> since_high_r == 16'(PULL_DELAY_CYCLES);
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("pull start mistimed");
	property p_settle;
		@(posedge clock_in) disable iff (!reset_n_in)
		$rose(pull_settled_out) |-> since_start_r == 16'(PULL_SETTLE_CYC);
	endproperty
	a_settle: assert property (p_settle) else $error("settle mistimed");
	property p_sw_oe;
		@(posedge clock_in) disable iff (!reset_n_in)
		sw_mode_r && $stable(sw_mode_r) && $stable(oe_bit_r) ##1 $stable(sw_mode_r) && $stable(oe_bit_r)
			|-> output_enable_out == oe_bit_r;
	endproperty
	a_sw_oe: assert property (p_sw_oe) else $error("enable not following bit");
	property p_oe_off;
		@(posedge clock_in) disable iff (!reset_n_in)
		sw_mode_r && !oe_bit_r ##1 sw_mode_r |-> !output_enable_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled early");
	property p_pin_ignore;
		@(posedge clock_in) disable iff (!reset_n_in)
		wr_high && !sw_mode_r |=> $stable(oe_bit_r);
	endproperty
	a_pin_ignore: assert property (p_pin_ignore) else $error("enable bit changed");
	property p_apply_on_start;
		@(posedge clock_in) disable iff (!reset_n_in)
		$changed(applied_word_out) |-> pull_start_out;
	endproperty
	a_apply_on_start: assert property (p_apply_on_start) else $error("word applied early");
	property p_span_map;
		@(posedge clock_in) disable iff (!reset_n_in)
		span_sel_r == 4'h7 && $stable(span_sel_r) |=> span_ppm_out == 12'h190;
	endproperty
	a_span_map: assert property (p_span_map) else $error("span ppm wrong");
	c_pull_start: cover property (@(posedge clock_in) disable iff (!reset_n_in) pull_start_out);
	c_settled: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		$rose(pull_settled_out));
	c_restart: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		state_r == PULL_DELAY && wr_high);
	c_sw_oe_on: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		sw_mode_r && $rose(output_enable_out));
endmodule // dco_pull_and_oe_registers

// ### dco_host_model.sv
`timescale 1ns/1ps
module dco_host_model
	import dco_pull_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic [DATA_W-1:0] rd_data_in,
	input  wire logic              rd_valid_in,
	output logic                   wr_en_out,
	output logic [ADDR_W-1:0]      wr_addr_out,
	output logic [DATA_W-1:0]      wr_data_out,
	output logic                   rd_en_out,
	output logic [ADDR_W-1:0]      rd_addr_out
);
	localparam int WORD_GAP = 2632;
	int cyc_h = 0;
	int last_word = -WORD_GAP;
	initial
	begin
		wr_en_out = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 16'h0000;
		rd_en_out = 1'b0;
		rd_addr_out = 8'h00;
	end
	always @(posedge clock_in)
		cyc_h <= cyc_h + 1;
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock_in);
		wr_en_out <= 1'b1;
		wr_addr_out <= a;
		wr_data_out <= d;
		@(negedge clock_in);
		wr_en_out <= 1'b0;
		wr_addr_out <= ~a;
		wr_data_out <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(negedge clock_in);
		rd_en_out <= 1'b1;
		rd_addr_out <= a;
		@(negedge clock_in);
		rd_en_out <= 1'b0;
		rd_addr_out <= ~a;
		d = rd_data_in;
		v = rd_valid_in;
	endtask
	task automatic write_word(input logic [9:0] hi, input logic [15:0] lo);
		while (cyc_h - last_word < WORD_GAP)
			@(negedge clock_in);
		write_reg(8'h00, lo);
		write_reg(8'h01, {6'h01, hi});
		last_word = cyc_h;
	endtask
endmodule // dco_host_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dco_pull_pkg::*;
	localparam int PD = 20;
	localparam logic [11:0] SPAN_TAB [16] = '{12'h019, 12'h032, 12'h050, 12'h064,
		12'h07D, 12'h096, 12'h0C8, 12'h190, 12'h258, 12'h320, 12'h4B0, 12'h640,
		12'hC80, 12'h000, 12'h000, 12'h000};
	logic              clock_in = 1'b0;
	logic              reset_n_in;
	logic              sw_oe_select_in;
	logic              oe_pin_in;
	logic              wr_en, rd_en, rd_valid;
	logic [7:0]        wr_addr, rd_addr;
	logic [15:0]       wr_data, rd_data;
	logic [25:0]       applied_word;
	logic [11:0]       span_ppm;
	logic              pull_start, pull_busy, pull_settled, oe;
	logic [4:0]        synth_int;
	logic [26:0]       synth_frac;
	logic [12:0]       out_div;
	logic              drv_stage;
	logic [5:0]        drive_ctrl;
	logic [15:0]       lf = 16'h0004;
	logic [15:0]       v [0:8];
	logic [15:0]       d, lo, lo2;
	logic [9:0]        hi;
	logic              vl;
	int                n_starts = 0;
	int                cyc = 0;
	int                t0;
	int                miscompares = 0;
	int                n_checks = 0;
	always #5 clock_in = ~clock_in;
	dco_pull_and_oe_registers #(.PULL_DELAY_CYCLES(PD)) dco_pull_and_oe_registers_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
		.wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_en_in(rd_en),
		.rd_addr_in(rd_addr), .sw_oe_select_in(sw_oe_select_in), .oe_pin_in(oe_pin_in),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .applied_word_out(applied_word),
		.span_ppm_out(span_ppm), .pull_start_out(pull_start), .pull_busy_out(pull_busy),
		.pull_settled_out(pull_settled), .output_enable_out(oe),
		.synth_int_out(synth_int), .synth_frac_out(synth_frac), .out_div_out(out_div),
		.drv_stage_div_out(drv_stage), .drive_ctrl_out(drive_ctrl));
	dco_host_model dco_host_model_inst (
		.clock_in(clock_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
		.wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.rd_en_out(rd_en), .rd_addr_out(rd_addr));
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] rmask(input logic [7:0] a);
		case (a)
			8'h00, 8'h03, 8'h04, 8'h05: rmask = 16'hFFFF;
			8'h01: rmask = 16'h07FF;
			8'h02, 8'h06: rmask = 16'h000F;
			default: rmask = 16'h0000;
		endcase
	endfunction
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic waitn(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	always @(posedge clock_in)
	begin
		cyc <= cyc + 1;
		if (pull_start === 1'b1)
			n_starts <= n_starts + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	initial
	begin
		reset_n_in = 1'b0;
		sw_oe_select_in = 1'b1;
		oe_pin_in = 1'b0;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		reset_n_in = 1'b1;
		waitn(6);
		for (int a = 0; a < 9; a++)
		begin
			dco_host_model_inst.read_reg(a[7:0], d, vl);
			chk(d, 16'h0000, "reset value");
			chk(vl, 1'b1, "read valid");
		end
		chk(applied_word, 26'h0000000, "applied word at reset");
		chk(oe, 1'b0, "output enable at reset");
		for (int p = 0; p < 18; p++)
		begin
			v[p % 9] = (p < 9) ? lf : ~lf;
			lf = lfsr_next(lf);
			dco_host_model_inst.write_reg(8'(p % 9), v[p % 9]);
			dco_host_model_inst.read_reg(8'(p % 9), d, vl);
			chk(d, v[p % 9] & rmask(8'(p % 9)), "register readback");
		end
		chk(synth_int, v[3][15:11], "integer divider");
		chk(synth_frac, {v[3][10:0], v[4]}, "fraction divider");
		chk(out_div, v[5][15:3], "output divider");
		chk({drv_stage, drive_ctrl}, {v[6][3], v[5][2:0], v[6][2:0]}, "drive bits");
		for (int c = 0; c < 16; c++)
		begin
			dco_host_model_inst.write_reg(8'h02, {lf[15:4], c[3:0]});
			lf = lfsr_next(lf);
			waitn(2);
			chk(span_ppm, SPAN_TAB[c], "span ppm");
		end
		for (int i = 0; i < 2; i++)
		begin
			hi = lf[9:0];
			lf = lfsr_next(lf);
			lo = lf;
			lf = lfsr_next(lf);
			lo2 = lf;
			lf = lfsr_next(lf);
			dco_host_model_inst.write_word(hi, lo);
			t0 = cyc;
			if (i == 0)
				dco_host_model_inst.write_reg(8'h00, lo2);
			else
			begin
				waitn(3);
				dco_host_model_inst.write_reg(8'h01, {6'h01, hi});
				t0 = cyc;
				lo2 = lo;
			end
			while (pull_start !== 1'b1 && cyc - t0 < 200)
				@(negedge clock_in);
			chk(cyc - t0, PD, "pull start delay");
			chk(pull_busy, 1'b1, "busy at start");
			chk(applied_word, {hi, lo2}, "applied word");
			t0 = cyc;
			while (pull_settled !== 1'b1 && cyc - t0 < 2200)
				@(negedge clock_in);
			chk(cyc - t0, PULL_SETTLE_CYC, "settle time");
			chk(pull_busy, 1'b0, "busy after settle");
		end
		t0 = n_starts;
		dco_host_model_inst.write_reg(8'h00, ~lo2);
		waitn(PD + 10);
		chk(n_starts - t0, 0, "no start on low word");
		chk(applied_word, {hi, lo2}, "word held");
		dco_host_model_inst.write_reg(8'h01, {6'h00, hi});
		waitn(2);
		chk(oe, 1'b0, "software disable");
		dco_host_model_inst.write_reg(8'h01, {6'h01, hi});
		waitn(2);
		chk(oe, 1'b1, "software enable");
		sw_oe_select_in = 1'b0;
		waitn(8);
		chk(oe, 1'b0, "pin mode low");
		dco_host_model_inst.write_reg(8'h01, {6'h00, hi});
		waitn(3);
		chk(oe, 1'b0, "enable bit ignored");
		dco_host_model_inst.read_reg(8'h01, d, vl);
		chk(d, {5'h00, 1'b1, hi}, "enable bit kept");
		oe_pin_in = 1'b1;
		waitn(8);
		chk(oe, 1'b1, "pin mode high");
		wrap_up();
	end
endmodule // tb_top
